//--- chdc_pkg.sv
// constants shared by the card command/data controller
package chdc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_CTRL2 = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [7:0] OFS_IRQ   = 8'h10;
	localparam logic [7:0] OFS_CMD   = 8'h14;
	localparam logic [7:0] OFS_DATA  = 8'h18;
	localparam logic [7:0] OFS_CLK   = 8'h1c;
	// card_control_0 bits
	localparam int B_RESPONSE_CHECK_DISABLE = 0;
	localparam int B_RESPONSE_SIZE_SELECT   = 1;
	localparam int B_DATA_FORMAT_SELECT   = 2;
	localparam int B_MBLK   = 3;
	localparam int B_CMD_TX_PTR_RESET  = 4;
	localparam int B_CMD_RX_PTR_RESET  = 5;
	localparam int B_DATA_TX_PTR_RESET  = 6;
	localparam int B_DATA_RX_PTR_RESET  = 7;
	// card_control_1 bits
	localparam int B_CSTART = 0;
	localparam int B_DSTART = 1;
	localparam int B_RESPONSE_EXPECTED = 2;
	localparam int B_DIR    = 3;
	localparam int B_BLEN   = 4;
	// card_control_2 bits
	localparam int B_CCR    = 0;
	localparam int B_WDLY   = 1;
	// token sizes and timing
	localparam int CMD_BYTES  = 5;
	localparam int TOK_BITS   = 48;
	localparam int RSP_LONG   = 136;
	localparam int HALF_DEPTH = 8;
	localparam int BLEN_MAX   = 11;
	localparam int WDLY_BASE  = 3;
	localparam int WDLY_STEP  = 2;
	localparam logic [6:0]  CRC7_POLY  = 7'h09;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [2:0]  TOK_OK     = 3'h2;
	localparam logic [7:0]  RST_CTRL0  = 8'h02;
endpackage

//--- chdc_ctrl.sv
// card command line and data line controller with apb registers
// Contract
// - check disable skips response crc7 check
// - lock command fifo while command sends
// - command end sets command done flag
// - tx pointer reset aborts command loading
// - response end sets response done flag
// - format ok on length+end bit; crc status
// - response status cleared on send, set after
// - rx pointer reset restarts response reading
// - sixteen byte fifo as two halves
// - data pointer resets abort transfer anytime
// - half empty and half full flags
// - stream or block, single or multi
// - block length two to the code
// - data waits for good response, not busy
// - write delay three plus two per step; later multi blocks wait three only
// - frame done after end bit or token
// - busy mirror and busy change flag
// - command token is forty-eight bits
// - card clock divides; zero stops it
// - reading flag register clears all flags
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module chdc_ctrl import chdc_pkg::*; #(
	parameter int DEPTH = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             card_clk,
	input  wire logic        cmd_in,
	output logic             cmd_out,
	output logic             cmd_oe,
	input  wire logic        dat_in,
	output logic             dat_out,
	output logic             dat_oe
);
	typedef enum logic [3:0] {
		C_IDLE = 4'b0001, C_SEND = 4'b0010, C_WAIT = 4'b0100, C_RECV = 4'b1000
	} chdc_cst_t;
	typedef enum logic [5:0] {
		D_IDLE = 6'b000001, D_ARM = 6'b000010, D_DLY = 6'b000100,
		D_SEND = 6'b001000, D_TOK = 6'b010000, D_BUSY = 6'b100000
	} chdc_dst_t;

	// serial crc steps; crc7 is shared by send and check paths, crc16 only sends
	function automatic logic [6:0] crc7(input logic [6:0] c, input logic b);
		crc7 = {c[5:0], 1'b0} ^ ((b ^ c[6]) ? CRC7_POLY : 7'h00);
	endfunction
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic b);
		crc16 = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? CRC16_POLY : 16'h0000);
	endfunction

	logic [7:0]  ctrl0_r, ctrl1_r, ctrl2_r, div_r;   // software registers
	logic [7:0]  irq_r;                               // sticky event flags
	logic [7:0]  dcnt_r;                              // divider count
	logic        cm1_r, cm2_r, dm1_r, dm2_r;          // pin synchronisers
	logic        cstart_q, dstart_q;                  // start bit history
	logic [7:0]  cq [CMD_BYTES];                      // command tx fifo
	logic [2:0]  cwp_r;                               // its write pointer
	logic        lock_r;                              // command fifo lock
	logic        cpend_r;                             // start seen, waiting for tick
	chdc_cst_t   cst_r;                               // command fsm
	logic [47:0] csr_r;                               // outgoing token
	logic [7:0]  cbit_r;                              // token bit counter
	logic [6:0]  ccrc_r;                              // crc7 accumulator
	logic [135:0] rsp_r;                              // received response
	logic [4:0]  crp_r;                               // response read ptr
	logic        rfok_r, rcok_r, rdone_r;             // response status
	logic [7:0]  dq [DEPTH];                          // data fifo store
	logic [3:0]  wp_r, rp_r;                          // hidden data pointers
	logic [3:0]  hcnt_r [2];                          // fill per half
	chdc_dst_t   dst_r;                               // data fsm
	logic [1:0]  dph_r;                               // start/data/crc/end
	logic [2:0]  dbit_r;                              // bit within byte
	logic [11:0] dbyte_r;                             // bytes sent in block
	logic [3:0]  c16n_r;                              // crc16 bit count
	logic [7:0]  dsr_r;                               // data byte shifter
	logic [15:0] dcrc_r;                              // crc16 accumulator
	logic [3:0]  tok_r;                               // crc status token
	logic [2:0]  tokn_r;                              // token bits taken
	logic [4:0]  dly_r;                               // write delay count
	logic        dfok_r, dcok_r, busy_r;              // data status

	// bus decode, the slave always answers in the access cycle
	wire acc  = psel && penable;
	wire wr   = acc && pwrite;
	wire rd   = acc && !pwrite;
	wire hit  = (paddr[1:0] == 2'b00) && (paddr <= OFS_CLK);
	wire wr0  = wr && paddr == OFS_CTRL0;
	wire wr1  = wr && paddr == OFS_CTRL1;
	wire wr2  = wr && paddr == OFS_CTRL2;
	wire wrc  = wr && paddr == OFS_CMD;
	wire wrd  = wr && paddr == OFS_DATA;
	wire rdi  = rd && paddr == OFS_IRQ;
	wire rdc  = rd && paddr == OFS_CMD;
	wire rdd  = rd && paddr == OFS_DATA;
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;

	// card clock: low half then high half of each divided period
	wire tick = (div_r != 8'h00) && (dcnt_r == div_r - 8'h01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dcnt_r   <= 8'h00;
			card_clk <= 1'b0;
		end else begin
			dcnt_r   <= (tick || div_r == 8'h00) ? 8'h00 : dcnt_r + 8'h01;
			card_clk <= (div_r != 8'h00) && !tick && (dcnt_r + 8'h01 >= (div_r >> 1));
		end
	end

	// pins pass two flops; only the second stage is ever read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cm1_r, cm2_r, dm1_r, dm2_r} <= 4'hf;
		end else begin
			{cm1_r, cm2_r, dm1_r, dm2_r} <= {cmd_in, cm1_r, dat_in, dm1_r};
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_r <= RST_CTRL0;
			ctrl1_r <= 8'h00;
			ctrl2_r <= 8'h00;
			div_r   <= 8'h00;
		end else begin
			if (wr0) ctrl0_r <= pwdata[7:0];
			if (wr1) ctrl1_r <= pwdata[7:0];
			if (wr2) ctrl2_r <= pwdata[7:0];
			if (wr && paddr == OFS_CLK) div_r <= pwdata[7:0];
		end
	end

	wire command_controller_reset      = ctrl2_r[B_CCR];
	wire cgo      = ctrl1_r[B_CSTART] && !cstart_q;
	wire dgo      = ctrl1_r[B_DSTART] && !dstart_q;
	wire rsp48    = ctrl0_r[B_RESPONSE_SIZE_SELECT];
	wire [7:0] rlen = rsp48 ? 8'(TOK_BITS) : 8'(RSP_LONG);
	wire cwr_ok   = wrc && !lock_r && cwp_r < 3'(CMD_BYTES);
	wire cmd_end  = cst_r == C_SEND && tick && cbit_r == 8'(TOK_BITS - 1);
	wire rsp_end  = cst_r == C_RECV && tick && cbit_r == rlen - 8'h01;

	// command tx fifo and token sender
	always_ff @(posedge pclk) begin
		if (cwr_ok) cq[cwp_r] <= pwdata[7:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cwp_r    <= 3'h0;
			cstart_q <= 1'b0;
			lock_r   <= 1'b0;
			cpend_r  <= 1'b0;
			cst_r    <= C_IDLE;
			csr_r    <= '1;
			cbit_r   <= 8'h00;
			ccrc_r   <= 7'h00;
		end else begin
			cstart_q <= ctrl1_r[B_CSTART];
			if (ctrl0_r[B_CMD_TX_PTR_RESET]) cwp_r <= 3'h0;
			else if (cwr_ok) cwp_r <= cwp_r + 3'h1;
			if (command_controller_reset) begin
				// controller reset drops any frame in flight
				cst_r   <= C_IDLE;
				lock_r  <= 1'b0;
				cpend_r <= 1'b0;
				csr_r   <= '1;
			end else begin
				case (cst_r)
					C_IDLE: if (cgo) begin
						lock_r  <= 1'b1;
						cpend_r <= 1'b1;
					end else if (cpend_r && tick) begin
						// launch on a card clock boundary: the start bit gets a full period
						cpend_r <= 1'b0;
						cst_r  <= C_SEND;
						cbit_r <= 8'h00;
						ccrc_r <= 7'h00;
						csr_r  <= {2'b01, cq[0][5:0], cq[1], cq[2], cq[3], cq[4],
							8'hff};
					end
					C_SEND: if (tick) begin
						// crc over start..argument, then splice it in
						if (cbit_r < 8'd39) begin
							ccrc_r <= crc7(ccrc_r, csr_r[47]);
							csr_r  <= {csr_r[46:0], 1'b1};
						end else if (cbit_r == 8'd39) begin
							csr_r  <= {crc7(ccrc_r, csr_r[47]), 1'b1, 40'hff_ffff_ffff};
						end else begin
							csr_r  <= {csr_r[46:0], 1'b1};
						end
						cbit_r <= cbit_r + 8'h01;
						if (cmd_end) begin
							lock_r <= 1'b0;
							cst_r  <= ctrl1_r[B_RESPONSE_EXPECTED] ? C_WAIT : C_IDLE;
						end
					end
					C_WAIT: if (tick && !cm2_r) begin
						cst_r  <= C_RECV;
						cbit_r <= 8'h01;
						ccrc_r <= crc7(7'h00, 1'b0);
					end
					C_RECV: if (tick) begin
						cbit_r <= cbit_r + 8'h01;
						if (rlen - cbit_r > 8'd8 && (rsp48 || rlen - cbit_r <= 8'd128))
							ccrc_r <= crc7(ccrc_r, cm2_r);
						if (rsp_end) cst_r <= C_IDLE;
					end
					default: cst_r <= C_IDLE;
				endcase
			end
		end
	end
	assign cmd_out = csr_r[47];
	assign cmd_oe  = cst_r == C_SEND;

	// response capture, status and the read side of the command port
	wire [7:0] shamt = (rsp48 ? 8'd40 : 8'd128) - {crp_r, 3'b000};
	wire [135:0] rsh = rsp_r >> shamt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_r  <= '0;
			crp_r  <= 5'h00;
			rfok_r <= 1'b0;
			rcok_r <= 1'b0;
			rdone_r <= 1'b0;
		end else begin
			// the start bit is kept too, so the top byte reads back from bit 47, or from bit 135 for a long response
			if (tick && (cst_r == C_RECV || (cst_r == C_WAIT && !cm2_r)))
				rsp_r <= {rsp_r[134:0], cm2_r};
			if (ctrl0_r[B_CMD_RX_PTR_RESET] || rsp_end) crp_r <= 5'h00;
			else if (rdc) crp_r <= crp_r + 5'h01;
			if (cst_r == C_IDLE && cgo && !command_controller_reset) begin
				rfok_r  <= 1'b0;
				rcok_r  <= 1'b0;
				rdone_r <= 1'b0;
			end else if (rsp_end) begin
				rfok_r  <= cm2_r;
				rcok_r  <= ctrl0_r[B_RESPONSE_CHECK_DISABLE] || ccrc_r == rsp_r[6:0];
				rdone_r <= 1'b1;
			end
		end
	end
	wire rsp_good = rdone_r && rfok_r && rcok_r;

	// data fifo: two halves selected by the pointer top bit
	wire [11:0] blen   = 12'h001 << ctrl1_r[B_BLEN +: 4];
	wire        dptr_rst = ctrl0_r[B_DATA_TX_PTR_RESET] || ctrl0_r[B_DATA_RX_PTR_RESET];
	wire        push   = wrd && hcnt_r[wp_r[3]] != 4'(HALF_DEPTH);
	wire        dempty = hcnt_r[rp_r[3]] == 4'h0;
	wire        dload  = dst_r == D_SEND && tick && dph_r == 2'd1 &&
		dbit_r == 3'h0 && !dempty;
	wire        pop    = dload || (rdd && !dempty);
	always_ff @(posedge pclk) begin
		if (push) dq[wp_r] <= pwdata[7:0];
	end
	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : g_half
			wire inc = push && wp_r[3] == h[0];
			wire dec = pop && rp_r[3] == h[0];
			// fill count per half gives the empty and full levels
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) hcnt_r[h] <= 4'h0;
				else if (dptr_rst) hcnt_r[h] <= 4'h0;
				else hcnt_r[h] <= hcnt_r[h] + {3'h0, inc} - {3'h0, dec};
			end
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r <= 4'h0;
			rp_r <= 4'h0;
		end else if (dptr_rst) begin
			wp_r <= 4'h0;
			rp_r <= 4'h0;
		end else begin
			if (push) wp_r <= wp_r + 4'h1;
			if (pop) rp_r <= rp_r + 4'h1;
		end
	end

	// data transmitter
	wire blk  = ctrl0_r[B_DATA_FORMAT_SELECT];
	wire last = blk && dbit_r == 3'h7 && dbyte_r + 12'h001 == blen;
	wire fdone = dst_r == D_TOK && tick && tokn_r == 3'h4;
	wire sdone = dst_r == D_SEND && tick && dph_r == 2'd3 && !blk;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dst_r <= D_IDLE; dph_r <= 2'd0; dbit_r <= 3'h0;
			dbyte_r <= 12'h000; c16n_r <= 4'h0; dsr_r <= 8'h00;
			dcrc_r <= 16'h0000; tok_r <= 4'h0; tokn_r <= 3'h0;
			dly_r <= 5'h00; dstart_q <= 1'b0; dat_out <= 1'b1;
			dfok_r <= 1'b0; dcok_r <= 1'b0; busy_r <= 1'b0;
		end else begin
			dstart_q <= ctrl1_r[B_DSTART];
			// busy mirrors the data line in the idle, arm and busy states
			if (tick && (dst_r == D_IDLE || dst_r == D_ARM || dst_r == D_BUSY))
				busy_r <= !dm2_r;
			if (dptr_rst) begin
				dst_r   <= D_IDLE;
				dat_out <= 1'b1;
			end else begin
				case (dst_r)
					D_IDLE: if (dgo && ctrl1_r[B_DIR]) dst_r <= D_ARM;
					D_ARM: if (rsp_good && !busy_r) begin
						dst_r <= D_DLY;
						dly_r <= 5'(WDLY_BASE) + 5'(WDLY_STEP) * {3'h0, ctrl2_r[B_WDLY +: 2]};
					end
					D_DLY: if (tick) begin
						dly_r <= dly_r - 5'h01;
						if (dly_r == 5'h01) begin
							dst_r <= D_SEND; dph_r <= 2'd0;
						end
					end
					D_SEND: if (tick) begin
						case (dph_r)
							2'd0: begin
								dat_out <= 1'b0;
								dcrc_r  <= 16'h0000;
								dbyte_r <= 12'h000;
								dbit_r  <= 3'h0;
								dph_r   <= 2'd1;
							end
							2'd1: if (dbit_r != 3'h0 || !dempty) begin
								dat_out <= dload ? dq[rp_r][7] : dsr_r[7];
								dsr_r   <= dload ? {dq[rp_r][6:0], 1'b0} : {dsr_r[6:0], 1'b0};
								dcrc_r  <= crc16(dcrc_r, dload ? dq[rp_r][7] : dsr_r[7]);
								dbit_r  <= dbit_r + 3'h1;
								if (dbit_r == 3'h7) dbyte_r <= dbyte_r + 12'h001;
								if (last) begin
									dph_r <= 2'd2; c16n_r <= 4'h0;
								end
							end else if (!blk) begin
								// a stream ends when software stops feeding it
								dat_out <= 1'b1;
								dph_r   <= 2'd3;
							end
							2'd2: begin
								dat_out <= dcrc_r[15];
								dcrc_r  <= {dcrc_r[14:0], 1'b0};
								c16n_r  <= c16n_r + 4'h1;
								if (c16n_r == 4'hf) dph_r <= 2'd3;
							end
							default: begin
								dat_out <= 1'b1;
								tokn_r  <= 3'h0;
								dst_r   <= blk ? D_TOK : D_IDLE;
							end
						endcase
					end
					D_TOK: if (tick && (tokn_r != 3'h0 || !dm2_r)) begin
						if (tokn_r != 3'h0) tok_r <= {tok_r[2:0], dm2_r};
						tokn_r <= tokn_r + 3'h1;
						if (fdone) begin
							dfok_r <= dm2_r;
							dcok_r <= {tok_r[1:0], tok_r[0]} == TOK_OK && tok_r[2:0] == TOK_OK;
							dst_r  <= D_BUSY;
						end
					end
					D_BUSY: if (tick && dm2_r) begin
						// multi-block goes on while data is waiting
						dst_r <= (ctrl0_r[B_MBLK] && !dempty) ? D_DLY : D_IDLE;
						dly_r <= 5'(WDLY_BASE);
					end
					default: dst_r <= D_IDLE;
				endcase
			end
		end
	end
	assign dat_oe = dst_r == D_SEND;

	// event flags; an event in the clearing read still lands
	logic busy_q, h1e_q, h2e_q, h1f_q, h2f_q;
	wire h1e = hcnt_r[0] == 4'h0;
	wire h2e = hcnt_r[1] == 4'h0;
	wire h1f = hcnt_r[0] == 4'(HALF_DEPTH);
	wire h2f = hcnt_r[1] == 4'(HALF_DEPTH);
	wire [7:0] fset = {busy_r != busy_q, h2f && !h2f_q, h1f && !h1f_q,
		h2e && !h2e_q, h1e && !h1e_q, fdone || sdone, rsp_end, cmd_end};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 8'h00;
			{busy_q, h1e_q, h2e_q, h1f_q, h2f_q} <= 5'b01100;
		end else begin
			{busy_q, h1e_q, h2e_q, h1f_q, h2f_q} <= {busy_r, h1e, h2e, h1f, h2f};
			irq_r <= (rdi ? 8'h00 : irq_r) | fset;
		end
	end

	// read mux
	wire [7:0] stat = {2'b00, busy_r, dcok_r, dfok_r, rcok_r, rfok_r, lock_r};
	always_comb begin
		case (paddr)
			OFS_CTRL0: prdata = {24'h0, ctrl0_r};
			OFS_CTRL1: prdata = {24'h0, ctrl1_r};
			OFS_CTRL2: prdata = {24'h0, ctrl2_r};
			OFS_STAT:  prdata = {24'h0, stat};
			OFS_IRQ:   prdata = {24'h0, irq_r};
			OFS_CMD:   prdata = {24'h0, rsh[7:0]};
			OFS_DATA:  prdata = {24'h0, dempty ? 8'h00 : dq[rp_r]};
			OFS_CLK:   prdata = {24'h0, div_r};
			default:   prdata = 32'h0;
		endcase
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cmd_go; cst_r == C_IDLE && cgo && !command_controller_reset; endsequence
	a_lock_blocks_wr: assert property (lock_r && wrc && !ctrl0_r[B_CMD_TX_PTR_RESET] |=> $stable(cwp_r))
		else $error("write entered a locked command fifo");
	a_cmd_done_flag: assert property (cmd_end |=> irq_r[0] && !lock_r)
		else $error("command end not flagged");
	a_rsp_cleared: assert property (s_cmd_go |=> !rfok_r && !rcok_r && lock_r)
		else $error("response status not cleared on send");
	a_crc_skip: assert property (rsp_end && ctrl0_r[B_RESPONSE_CHECK_DISABLE] |=> rcok_r && irq_r[1])
		else $error("check disable did not pass response");
	a_div_stop: assert property (div_r == 8'h00 |-> !tick ##1 !card_clk)
		else $error("card clock runs with zero divider");
	a_flag_clear: assert property (rdi |=> irq_r == $past(fset))
		else $error("flag read did not clear flags");
	a_half_bound: assert property (hcnt_r[0] <= 4'd8 && hcnt_r[1] <= 4'd8)
		else $error("fifo half overfilled");
	a_busy_flag: assert property ($changed(busy_r) |=> irq_r[7])
		else $error("busy change not flagged");
	a_ptr_reset: assert property (ctrl0_r[B_CMD_TX_PTR_RESET] |=> cwp_r == 3'h0)
		else $error("command write pointer not reset");
	a_tok_len: assert property (cmd_oe |-> cbit_r < 8'd48)
		else $error("command token too long");
endmodule

//--- chdc_card_model.sv
// behavioural card on the command line: captures tokens and answers them
`timescale 1ns/1ps
module chdc_card_model #(
	parameter logic [31:0] RSP_STATUS = 32'h0000_0900 // card status echoed back
) (
	input  wire logic        card_clk,
	input  wire logic        cmd_out,
	input  wire logic        cmd_oe,
	input  wire logic        bad_crc,
	input  wire logic [5:0]  rsp_delay,
	output logic             cmd_in,
	output logic             dat_in,
	output logic      [47:0] last_tok
);
	logic        drv;   // card drives the command line
	logic        bit_v; // bit the card drives
	logic [47:0] sh;    // token being captured
	logic [47:0] rsp;   // response being sent
	// crc7, polynomial x^7 + x^3 + 1, msb first
	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		logic       fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
		end
		return c;
	endfunction
	// a released command line floats high through its pull-up
	assign cmd_in = cmd_oe ? cmd_out : (drv ? bit_v : 1'b1);
	// data line idles high: the card never signals busy here
	assign dat_in = 1'b1;
	// card samples on rising card clock, host changes on falling
	initial begin
		drv      = 1'b0;
		bit_v    = 1'b1;
		last_tok = 48'h0;
		forever begin
			@(posedge card_clk iff (cmd_oe === 1'b1 && cmd_out === 1'b0));
			sh = 48'h0;
			repeat (47) begin
				@(posedge card_clk);
				sh = {sh[46:0], cmd_out};
			end
			last_tok = sh;
			// answer well inside the 64-period limit, prompt or slow
			repeat (rsp_delay) @(posedge card_clk);
			rsp = {2'b00, sh[45:40], RSP_STATUS, 8'h01};
			rsp[7:1] = crc7(rsp[47:8]) ^ {6'h0, bad_crc};
			for (int i = 47; i >= 0; i--) begin
				@(posedge card_clk);
				drv   = 1'b1;
				bit_v = rsp[i];
			end
			@(posedge card_clk);
			drv = 1'b0;
		end
	end
endmodule

//--- tb.sv
// self-checking bench for the card command and data line controller
`timescale 1ns/1ps
module tb import chdc_pkg::*; ;
	logic        pclk = 1'b0;      // 40 MHz bus clock
	logic        presetn = 1'b0;   // async reset, active low
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        card_clk;
	logic        cmd_in;
	logic        cmd_out;
	logic        cmd_oe;
	logic        dat_in;
	logic        dat_out;
	logic        dat_oe;
	logic        bad_crc = 1'b0;   // card corrupts its response crc
	logic [5:0]  rsp_delay = 6'h02; // card answer delay in card clocks
	logic [47:0] last_tok;         // last command token seen by the card
	logic [31:0] q;                // last read data
	logic        err;              // last slave error
	logic [7:0]  seen;             // flags gathered while polling
	logic [31:0] c0;               // shadow of card_control_0
	int          n_mismatch = 0;
	int          comparisons = 0;
	chdc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .card_clk(card_clk), .cmd_in(cmd_in), .cmd_out(cmd_out),
		.cmd_oe(cmd_oe), .dat_in(dat_in), .dat_out(dat_out), .dat_oe(dat_oe));
	chdc_card_model card (.card_clk(card_clk), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
		.bad_crc(bad_crc), .rsp_delay(rsp_delay), .cmd_in(cmd_in), .dat_in(dat_in),
		.last_tok(last_tok));
	// bus clock
	always #12.5 pclk = ~pclk;
	// compare and count
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; holds everything until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			n_mismatch++;
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// poll the flag register, which clears on read, until all of m were seen
	task automatic wait_irq(input logic [7:0] m);
		for (int i = 0; i < 3000 && (seen & m) !== m; i++) begin
			apb(1'b0, OFS_IRQ, 32'h0);
			seen = seen | q[7:0];
		end
		chk(seen & m, m);
		if ((seen & m) !== m) test_done();
	endtask
	// reset values and an unmapped address
	task automatic t_reset();
		rd_chk(OFS_CTRL0, 32'h02);
		rd_chk(OFS_STAT, 32'h00);
		rd_chk(OFS_IRQ, 32'h00);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
	endtask
	// load junk, abort it, load a command, send it and judge the answer
	task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic ok);
		wr(OFS_CMD, 32'h3f);
		wr(OFS_CMD, 32'haa);
		wr(OFS_CTRL0, c0 | 32'h10);
		wr(OFS_CTRL0, c0);
		wr(OFS_CMD, {26'h0, idx});
		for (int k = 3; k >= 0; k--) wr(OFS_CMD, {24'h0, arg[k*8 +: 8]});
		seen = 8'h00;
		wr(OFS_CTRL1, 32'h05);
		wr(OFS_CTRL1, 32'h04);
		rd_chk(OFS_STAT, 32'h01);
		wait_irq(8'h03);
		chk(last_tok, {2'b01, idx, arg, card.crc7({2'b01, idx, arg}), 1'b1});
		rd_chk(OFS_STAT, {29'h0, ok, 2'b10});
		rd_chk(OFS_CMD, {26'h0, idx});
	endtask
	// good crc, bad crc checked, bad crc with checking off
	task automatic t_cmd();
		wr(OFS_CLK, 32'h08);
		for (int j = 0; j < 3; j++) begin
			bad_crc   <= (j > 0);
			rsp_delay <= (j == 1) ? 6'd40 : 6'd2;
			c0 = (j == 2) ? 32'h03 : 32'h02;
			send_cmd(6'(j + 17), 32'h1234_5678 + j, j != 1);
		end
	endtask
	// fill each half, then abort with a pointer reset
	task automatic t_fifo();
		wr(OFS_CTRL1, 32'h08);
		for (int k = 0; k < 8; k++) wr(OFS_DATA, 32'h10 + k);
		rd_chk(OFS_IRQ, 32'h20);
		for (int k = 0; k < 8; k++) wr(OFS_DATA, 32'h20 + k);
		rd_chk(OFS_IRQ, 32'h40);
		wr(OFS_CTRL0, 32'h42);
		wr(OFS_CTRL0, 32'h02);
		rd_chk(OFS_IRQ, 32'h18);
	endtask
	// stream write after a good response: delay, bytes, end bit, frame done
	task automatic t_data();
		wr(OFS_CTRL0, 32'h02);
		wr(OFS_DATA, 32'h5a);
		wr(OFS_DATA, 32'hc3);
		seen = 8'h00;
		wr(OFS_CTRL1, 32'h0a);
		wr(OFS_CTRL1, 32'h08);
		wait_irq(8'h04);
		rd_chk(OFS_STAT, 32'h06);
	endtask
	// count card clock rising edges over a number of bus cycles
	task automatic count_clk(input int cyc, output int n);
		logic p;
		n = 0;
		p = card_clk;
		repeat (cyc) begin
			@(posedge pclk);
			#1;
			if (card_clk === 1'b1 && p === 1'b0) n++;
			p = card_clk;
		end
	endtask
	// divider zero stops the card clock, four divides by four
	task automatic t_clock();
		int n;
		wr(OFS_CLK, 32'h00);
		count_clk(40, n);
		chk(n, 0);
		wr(OFS_CLK, 32'h04);
		count_clk(80, n);
		chk(n >= 19 && n <= 21, 1'b1);
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_cmd();
		t_fifo();
		t_data();
		t_clock();
		test_done();
	end
endmodule
